// ---- pkg/tms_regs.svh ----
// Register map constants for the timer channel mode select block.
// Assumes inclusion by bare name from design files.
`ifndef TMS_REGS_SVH
`define TMS_REGS_SVH
// ==========================================
// Offsets (byte addresses, one word each)
`define TMS_MODE_CH0_OFS 4'h0
`define TMS_MODE_CH1_OFS 4'h4
`define TMS_MODE_CH2_OFS 4'h8
`define TMS_STATUS_OFS 4'hC
// ==========================================
// Field positions
`define TMS_FLD_MODE_LSB 0
`define TMS_FLD_MODE_MSB 2
`define TMS_FLD_MODE_TOP 3
`define TMS_FLD_BUF_A 4
`define TMS_FLD_BUF_B 5
// ==========================================
// Reset and fixed values
`define TMS_MODE_RST 8'hC0
`define TMS_RSVD_ONES 8'hC0
`define TMS_UNMAPPED_RD 32'h0000_0000
`endif

// ---- pkg/tms_pkg.sv ----
// Types shared by the timer channel mode select block.
// Assumes tms_regs.svh sits beside it.
package tms_pkg;
  // One-hot decoded operating mode
  typedef enum logic [7:0] {
    TMS_NORMAL = 8'h01,
    TMS_PWM1 = 8'h02,
    TMS_PWM2 = 8'h04,
    TMS_PHASE1 = 8'h08,
    TMS_PHASE2 = 8'h10,
    TMS_PHASE3 = 8'h20,
    TMS_PHASE4 = 8'h40,
    TMS_RSVD = 8'h80
  } tms_mode_t;
  typedef enum logic [1:0] {
    TMS_BUS_IDLE = 2'b01,
    TMS_BUS_ACK = 2'b10
  } tms_bus_t;
endpackage : tms_pkg

// ---- verilog/tms_mode_decode.sv ----
// Decoder from a channel's mode field to a one-hot operating mode.
// Assumes a stored mode register value on its input.
`timescale 1ns/1ns
module tms_mode_decode (
  input wire logic [2:0] mode_field,
  output tms_pkg::tms_mode_t mode
);
  // ==========================================
  // Decode of the three low mode bits
  always_comb begin
    case (mode_field)
      3'b000: mode = tms_pkg::TMS_NORMAL;
      3'b001: mode = tms_pkg::TMS_NORMAL; // Reserved code treated as normal
      3'b010: mode = tms_pkg::TMS_PWM1;
      3'b011: mode = tms_pkg::TMS_PWM2;
      3'b100: mode = tms_pkg::TMS_PHASE1;
      3'b101: mode = tms_pkg::TMS_PHASE2;
      3'b110: mode = tms_pkg::TMS_PHASE3;
      default: mode = tms_pkg::TMS_PHASE4;
    endcase
  end
endmodule : tms_mode_decode

// ---- verilog/tms_mode_select.sv ----
// Mode registers for a three-channel timer, reached over Avalon-MM.
// Assumes a synchronous Avalon master on sys_clk; counters live elsewhere.
`timescale 1ns/1ns
`include "tms_regs.svh"

// Functional notes
// - Top two mode register bits always read one; writes ignored.
// - Channel 0 bit 5 pairs register B with register D for buffering.
// - Register D raises no capture or compare events while buffering B.
// - Channel 0 bit 4 pairs register A with register C for buffering.
// - Register C raises no capture or compare events while buffering A.
// - Channels 1 and 2 bit 5 reads zero, ignores writes.
// - Channels 1 and 2 bit 4 reads zero, ignores writes.
// - Mode codes: normal, reserved, PWM1, PWM2, phase counting 1 to 4.
// - Channel 1 in phase counting ignores its clock source selection.
module tms_mode_select #(
  parameter int NUM_CH = 3
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] ch_running,
  input wire logic [2:0] ch0_d_event_raw,
  input wire logic [2:0] ch0_c_event_raw,
  output logic ch0_d_event,
  output logic ch0_c_event,
  output logic buffer_pair_a_enable,
  output logic buffer_pair_b_enable,
  output logic [7:0] ch0_mode,
  output logic [7:0] ch1_mode,
  output logic [7:0] ch2_mode,
  output logic ch1_clk_sel_ignore
);
  // ==========================================
  // Elaboration check
  if (NUM_CH != 3) begin : g_bad_ch
    $error("tms_mode_select serves exactly three channels");
  end

  logic [7:0] mode_q [3];
  logic [31:0] readdata_q;
  logic waitreq_q;
  tms_pkg::tms_bus_t bus_q;
  logic [2:0] running_q;
  logic wr_while_run_q;
  tms_pkg::tms_mode_t dec_mode [3];

  // Write mask per channel: channel 0 keeps buffer bits, others keep mode only
  function automatic logic [7:0] wr_mask(input int ch);
    wr_mask = (ch == 0) ? 8'h3F : 8'h0F;
  endfunction : wr_mask

  function automatic logic is_phase(input tms_pkg::tms_mode_t m);
    is_phase = (m == tms_pkg::TMS_PHASE1) || (m == tms_pkg::TMS_PHASE2) ||
               (m == tms_pkg::TMS_PHASE3) || (m == tms_pkg::TMS_PHASE4);
  endfunction : is_phase

  logic acc_ok;
  // Writes land at the edge that sees waitrequest low, never while the master still waits
  assign acc_ok = (bus_q == tms_pkg::TMS_BUS_ACK) && avs_byteenable[0];

  // ==========================================
  // Bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_q <= tms_pkg::TMS_BUS_IDLE;
      waitreq_q <= 1'b1;
    end else begin
      // Idle takes a request; the answer state always falls back to idle
      case (bus_q)
        tms_pkg::TMS_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= tms_pkg::TMS_BUS_ACK;
            waitreq_q <= 1'b0;
          end
        end
        default: begin
          bus_q <= tms_pkg::TMS_BUS_IDLE;
          waitreq_q <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // Mode registers, one per channel
  for (genvar ch = 0; ch < 3; ch++) begin : g_ch
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        mode_q[ch] <= `TMS_MODE_RST;
      end else if (avs_write && acc_ok && avs_address == 4'(ch * 4)) begin
        // Fixed bits forced; writable bits masked per channel
        mode_q[ch] <= `TMS_RSVD_ONES | (avs_writedata[7:0] & wr_mask(ch));
      end
    end
    tms_mode_decode u_dec (
      .mode_field(mode_q[ch][`TMS_FLD_MODE_MSB:`TMS_FLD_MODE_LSB]),
      .mode(dec_mode[ch])
    );
  end

  // ==========================================
  // Sticky flag: write landed on a channel while its own counter ran; misuse shown, not blocked
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      running_q <= 3'b000;
      wr_while_run_q <= 1'b0;
    end else begin
      running_q <= ch_running;
      // Only mapped mode offsets count; a stray unaligned write must not raise it
      if (avs_write && acc_ok && avs_address < `TMS_STATUS_OFS && avs_address[1:0] == 2'b00 &&
          running_q[avs_address[3:2]]) begin
        wr_while_run_q <= 1'b1;
      end else if (avs_write && acc_ok && avs_address == `TMS_STATUS_OFS && avs_writedata[0]) begin
        wr_while_run_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Read data, if/else-if decode; unmapped reads zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata_q <= `TMS_UNMAPPED_RD;
    end else if (avs_read && bus_q == tms_pkg::TMS_BUS_IDLE) begin
      if (avs_address == `TMS_MODE_CH0_OFS) begin
        readdata_q <= {24'h00_0000, mode_q[0]};
      end else if (avs_address == `TMS_MODE_CH1_OFS) begin
        readdata_q <= {24'h00_0000, mode_q[1]};
      end else if (avs_address == `TMS_MODE_CH2_OFS) begin
        readdata_q <= {24'h00_0000, mode_q[2]};
      end else if (avs_address == `TMS_STATUS_OFS) begin
        // Bit 1 clock select ignore, bit 0 sticky misuse flag
        readdata_q <= {30'h0000_0000, ch1_clk_sel_ignore, wr_while_run_q};
      end else begin
        readdata_q <= `TMS_UNMAPPED_RD;
      end
    end
  end

  // ==========================================
  // Registered outputs; buffer pairing gates events of C and D
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ch0_d_event <= 1'b0;
      ch0_c_event <= 1'b0;
      buffer_pair_a_enable <= 1'b0;
      buffer_pair_b_enable <= 1'b0;
      ch1_clk_sel_ignore <= 1'b0;
      ch0_mode <= `TMS_MODE_RST;
      ch1_mode <= `TMS_MODE_RST;
      ch2_mode <= `TMS_MODE_RST;
    end else begin
      buffer_pair_b_enable <= mode_q[0][`TMS_FLD_BUF_B];
      buffer_pair_a_enable <= mode_q[0][`TMS_FLD_BUF_A];
      ch0_d_event <= |ch0_d_event_raw & ~mode_q[0][`TMS_FLD_BUF_B];
      ch0_c_event <= |ch0_c_event_raw & ~mode_q[0][`TMS_FLD_BUF_A];
      ch1_clk_sel_ignore <= is_phase(dec_mode[1]);
      ch0_mode <= mode_q[0];
      ch1_mode <= mode_q[1];
      ch2_mode <= mode_q[2];
    end
  end

  assign avs_readdata = readdata_q;
  assign avs_waitrequest = waitreq_q;

  // ==========================================
  // Assertions
  sequence s_write_ch(int ch);
    avs_write && acc_ok && avs_address == 4'(ch * 4);
  endsequence

  top_ones_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ch0_mode[7:6] == 2'b11 && ch1_mode[7:6] == 2'b11 && ch2_mode[7:6] == 2'b11)
    else $error("mode top bits not one");
  ch1_bufbits_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_write_ch(1) |=> ##1 ch1_mode[5:4] == 2'b00)
    else $error("channel 1 buffer bits not zero");
  ch2_bufbits_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_write_ch(2) |=> ##1 ch2_mode[5:4] == 2'b00)
    else $error("channel 2 buffer bits not zero");
  pair_b_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_write_ch(0) |=> ##1 buffer_pair_b_enable == $past(avs_writedata[5], 2))
    else $error("pair B enable not from write");
  pair_a_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_write_ch(0) |=> ##1 buffer_pair_a_enable == $past(avs_writedata[4], 2))
    else $error("pair A enable not from write");
  d_suppress_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode_q[0][`TMS_FLD_BUF_B] |=> !ch0_d_event)
    else $error("D event while buffering");
  c_suppress_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode_q[0][`TMS_FLD_BUF_A] |=> !ch0_c_event)
    else $error("C event while buffering");

  // ==========================================
  // Events pass when pairing is off; reserved bits stay clear at all times
  d_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !mode_q[0][`TMS_FLD_BUF_B] && (|ch0_d_event_raw) |=> ch0_d_event)
    else $error("D event lost without pairing");
  c_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !mode_q[0][`TMS_FLD_BUF_A] && (|ch0_c_event_raw) |=> ch0_c_event)
    else $error("C event lost without pairing");
  rsvd_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode_q[1][5:4] == 2'b00 && mode_q[2][5:4] == 2'b00)
    else $error("reserved buffer bits set");
  phase_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> ch1_clk_sel_ignore == $past(mode_q[1][2]))
    else $error("phase decode wrong");
  phase_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_write_ch(1) ##1 1'b1 |=> ch1_clk_sel_ignore == $past(avs_writedata[2], 2))
    else $error("clock select ignore wrong");
  wait_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // One wait cycle
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule : tms_mode_select

// ---- sim/tb_top.sv ----
// Self-checking bench for the timer channel mode select block.
// Assumes Avalon-MM with waitrequest, one clock, async active-low reset.
`timescale 1ns/1ns
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] ch_running = 3'h0;
  logic [2:0] ch0_d_event_raw = 3'h0;
  logic [2:0] ch0_c_event_raw = 3'h0;
  logic ch0_d_event, ch0_c_event, buffer_pair_a_enable, buffer_pair_b_enable, ch1_clk_sel_ignore;
  logic [7:0] ch0_mode, ch1_mode, ch2_mode;
  logic [31:0] rdat;
  int failures = 0;
  int total_checks = 0;
  typedef struct {logic [3:0] addr; logic [7:0] wdat; logic [7:0] rexp;} tms_row_t;
  // Ordinary accesses: address, write value, expected read-back
  // Stimulus keeps bit 3 zero, and bit 2 zero on channel 0
  tms_row_t rows [6] = '{'{4'h0, 8'h30, 8'hF0}, '{4'h0, 8'h02, 8'hC2}, '{4'h0, 8'h03, 8'hC3},
                         '{4'h4, 8'h37, 8'hC7}, '{4'h8, 8'h34, 8'hC4}, '{4'h0, 8'h00, 8'hC0}};
  // ==========================================
  // Clock and device
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  tms_mode_select #(.NUM_CH(3)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ch_running(ch_running), .ch0_d_event_raw(ch0_d_event_raw), .ch0_c_event_raw(ch0_c_event_raw),
    .ch0_d_event(ch0_d_event), .ch0_c_event(ch0_c_event), .buffer_pair_a_enable(buffer_pair_a_enable),
    .buffer_pair_b_enable(buffer_pair_b_enable), .ch0_mode(ch0_mode), .ch1_mode(ch1_mode),
    .ch2_mode(ch2_mode), .ch1_clk_sel_ignore(ch1_clk_sel_ignore));
  // ==========================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // One bus access; holds the request until waitrequest is seen low
  task automatic bus(input logic is_wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= is_wr;
    avs_read <= ~is_wr;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      failures++;
      print_verdict();
    end
  endtask : bus
  // Raise both raw events for one cycle, check the filtered outputs
  task automatic ev(input logic exp);
    @(posedge sys_clk);
    ch0_d_event_raw <= 3'h7;
    ch0_c_event_raw <= 3'h7;
    @(posedge sys_clk);
    ch0_d_event_raw <= 3'h0;
    ch0_c_event_raw <= 3'h0;
    #1;
    chk(ch0_d_event, exp);
    chk(ch0_c_event, exp);
  endtask : ev
  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    chk(ch0_mode, 8'hC0);
    chk(avs_waitrequest, 1'b1);
    rst_b <= 1'b1;
    bus(1'b0, 4'h4, 8'h00, 4'hF);
    chk(rdat[7:0], 8'hC0);
    $display("test reset done");
    // Table of ordinary writes and read-backs
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].wdat, 4'hF);
      bus(1'b0, rows[i].addr, 8'h00, 4'hF);
      chk(rdat[7:0], rows[i].rexp);
      #1;
      chk(rows[i].addr == 4'h0 ? ch0_mode : (rows[i].addr == 4'h4 ? ch1_mode : ch2_mode), rows[i].rexp);
      if (rows[i].addr == 4'h0) begin
        chk(buffer_pair_a_enable, rows[i].rexp[4]);
        chk(buffer_pair_b_enable, rows[i].rexp[5]);
      end
    end
    $display("test rows done");
    // Every mode code on channel 1; only phase codes ignore the clock select
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 4'h4, 8'(c), 4'hF);
      bus(1'b0, 4'hC, 8'h00, 4'hF);
      chk(rdat[1], c[2]);
      chk(ch1_clk_sel_ignore, c[2]);
    end
    $display("test codes done");
    // Event suppression with pairing on, then off
    bus(1'b1, 4'h0, 8'h30, 4'hF);
    ev(1'b0);
    bus(1'b1, 4'h0, 8'h00, 4'hF);
    ev(1'b1);
    $display("test events done");
    // Disabled low lane and an unmapped address leave registers alone
    bus(1'b1, 4'h0, 8'h02, 4'hE);
    bus(1'b1, 4'h2, 8'h33, 4'hF);
    bus(1'b0, 4'h2, 8'h00, 4'hF);
    chk(rdat, 32'h0000_0000);
    bus(1'b0, 4'h0, 8'h00, 4'hF);
    chk(rdat[7:0], 8'hC0);
    $display("test refusals done");
    // Write while running raises the sticky flag; writing one clears it
    ch_running <= 3'h4;
    bus(1'b1, 4'h8, 8'h02, 4'hF);
    ch_running <= 3'h0;
    bus(1'b0, 4'hC, 8'h00, 4'hF);
    chk(rdat[0], 1'b1);
    bus(1'b1, 4'hC, 8'h01, 4'hF);
    bus(1'b0, 4'hC, 8'h00, 4'hF);
    chk(rdat[0], 1'b0);
    $display("test status done");
    print_verdict();
  end
endmodule : tb_top
